// file: rtl/ubci_pkg.sv
// Package: constants and carrier types for the boot command interpreter
package ubci_pkg;
   // Command packet layout
   localparam int          UBCI_CMD_BYTES      = 32;
   localparam logic [31:0] UBCI_SIGNATURE      = 32'h431FD10B;
   localparam logic [4:0]  UBCI_OFS_SIGNATURE  = 5'h00;
   localparam logic [4:0]  UBCI_OFS_TAG        = 5'h04;
   localparam logic [4:0]  UBCI_OFS_CODE       = 5'h08;
   localparam logic [4:0]  UBCI_OFS_ARGLEN     = 5'h09;
   localparam logic [4:0]  UBCI_OFS_PAYLOAD    = 5'h0C;
   localparam logic [4:0]  UBCI_OFS_ARGS       = 5'h10;
   localparam logic [4:0]  UBCI_OFS_ARG1       = 5'h14;
   localparam logic [4:0]  UBCI_OFS_DELAY      = 5'h18;
   localparam int          UBCI_ARGS_BYTES     = 16;
   localparam logic [7:0]  UBCI_DIR_IN_BIT     = 8'h80;
   // Command codes and argument lengths
   localparam logic [7:0]  UBCI_CODE_ACCESS    = 8'h01;
   localparam logic [7:0]  UBCI_LEN_ACCESS     = 8'h01;
   localparam logic [7:0]  UBCI_CODE_RESTART   = 8'h02;
   localparam logic [7:0]  UBCI_LEN_RESTART    = 8'h0C;
   localparam logic [7:0]  UBCI_CODE_ERASE     = 8'h03;
   localparam logic [7:0]  UBCI_LEN_ERASE      = 8'h08;
   localparam logic [7:0]  UBCI_CODE_READ      = 8'h84;
   localparam logic [7:0]  UBCI_LEN_READ       = 8'h08;
   // Access levels
   localparam logic [7:0]  UBCI_LVL_OPEN       = 8'h00;
   localparam logic [7:0]  UBCI_LVL_NOWRITE    = 8'h01;
   localparam logic [7:0]  UBCI_LVL_EJECT      = 8'h02;
   // Erase granule, 4 kB sectors
   localparam logic [31:0] UBCI_SECTOR_MASK    = 32'h00000FFF;
   // Millisecond tick at 100 MHz
   localparam int          UBCI_CLK_HZ         = 100_000_000;
   localparam int          UBCI_MS_PER_S       = 1000;
   localparam int          UBCI_MS_CYCLES      = UBCI_CLK_HZ / UBCI_MS_PER_S;
   // Failure codes kept for status readback
   localparam logic [3:0]  UBCI_ST_OK          = 4'h0;
   localparam logic [3:0]  UBCI_ST_BAD_SIG     = 4'h1;
   localparam logic [3:0]  UBCI_ST_UNKNOWN     = 4'h2;
   localparam logic [3:0]  UBCI_ST_BAD_ARG     = 4'h3;
   localparam logic [3:0]  UBCI_ST_BAD_LEN     = 4'h4;
   localparam logic [3:0]  UBCI_ST_MEM_ERR     = 4'h5;

   // Decoded command carrier
   typedef struct packed {
      logic [31:0] request_tag;
      logic [7:0]  command_code;
      logic [7:0]  argument_length;
      logic [31:0] payload_byte_count;
      logic [31:0] arg0;
      logic [31:0] arg1;
      logic [31:0] arg2;
   } ubci_cmd_t;

   // Memory job carrier (erase or read)
   typedef struct packed {
      logic        erase;
      logic [31:0] target_address;
      logic [31:0] request_byte_count;
   } ubci_mem_req_t;

   // Status readback carrier
   typedef struct packed {
      logic [31:0] request_tag;
      logic [7:0]  command_code;
      logic [3:0]  status;
      logic        busy;
   } ubci_status_t;
endpackage

// file: rtl/ubci_pkt_asm.sv
// Byte assembler that gathers one 32-byte command packet
`timescale 1ns/10ps
module ubci_pkt_asm
   import ubci_pkg::*;
(
   // Clock and reset
   input  wire logic                         CLK_I,
   input  wire logic                         ARST_N_I,
   // Bulk OUT byte stream
   input  wire logic                         byte_valid_i,
   input  wire logic [7:0]                   byte_data_i,
   input  wire logic                         pkt_end_i,
   input  wire logic                         enable_i,
   // Assembled packet
   output logic                              pkt_valid_o,
   output logic                              pkt_size_ok_o,
   output logic [UBCI_CMD_BYTES*8-1:0]       pkt_data_o
);
   logic [7:0] buf_ff [UBCI_CMD_BYTES];
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic       done_ff;
   logic       ok_ff;
   wire        take = enable_i & byte_valid_i;
   wire        full = (cnt_ff == 6'(UBCI_CMD_BYTES));

   // Count stops at 32 so a longer packet is seen as wrong size
   assign nxt_cnt = (take & ~full) ? cnt_ff + 6'h01 : cnt_ff;

   // Byte store
   always_ff @(posedge CLK_I)
   begin
      if (take & ~full)
         buf_ff[cnt_ff[4:0]] <= byte_data_i;
   end

   // Count and packet boundary
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         cnt_ff  <= 6'h00;
         done_ff <= 1'b0;
         ok_ff   <= 1'b0;
      end
      else
      begin
         done_ff <= enable_i & pkt_end_i;
         ok_ff   <= (nxt_cnt == 6'(UBCI_CMD_BYTES)) & ~(take & full);
         cnt_ff  <= (enable_i & pkt_end_i) ? 6'h00 : nxt_cnt;
      end
   end

   // Flatten, byte 0 in the low bits
   always_comb
   begin
      for (int i = 0; i < UBCI_CMD_BYTES; i++)
         pkt_data_o[i*8 +: 8] = buf_ff[i];
   end

   assign pkt_valid_o   = done_ff;
   assign pkt_size_ok_o = ok_ff;
endmodule

// file: rtl/ubci_top.sv
// Boot command interpreter: parses bulk OUT commands, runs them, acks
// Operation
// - Descriptor: vendor class, subclass 0, protocol 0, two endpoints.
// - Exactly one bulk OUT and one bulk IN endpoint, found by type.
// - Commands are single 32-byte packets, parsed only from bulk OUT.
// - Packet starts with signature word, then host request tag at 0x04.
// - Code byte at 0x08; top bit set means data phase is IN.
// - Argument length byte gives valid bytes of argument area.
// - Payload byte count at 0x0C gives bytes moved on the bulk pipe.
// - Sixteen-byte argument area at 0x10, unused bytes zero.
// - Invalid command stalls both bulk endpoints, keeps failure status.
// - Non-zero payload moves exactly that count, then opposite empty; code sends an IN empty packet after read data.
// - Zero payload completes with a zero-length IN packet.
// - Access claim code 0x01 takes one-byte level; zero is unrestricted.
// - Level 1 write-protects mass storage and aborts active download.
// - Level 2 reports mass-storage media not present.
// - Restart code 0x02 waits delay milliseconds then leaves boot select.
// - Zero restart address uses normal flash boot path.
// - Erase code 0x03 erases contiguous sectors from address and count.
// - Read code 0x84 returns count bytes from address over bulk IN.
`timescale 1ns/10ps
module ubci_top
   import ubci_pkg::*;
#(
   parameter int MS_CYCLES = UBCI_MS_CYCLES
)
(
   // Clock and reset
   input  wire logic                CLK_I,
   input  wire logic                ARST_N_I,
   // Bulk OUT endpoint, byte stream from the USB core
   input  wire logic                OUT_VALID_I,
   input  wire logic [7:0]          OUT_DATA_I,
   input  wire logic                OUT_PKT_END_I,
   output logic                     OUT_READY_O,
   output logic                     OUT_STALL_O,
   // Bulk IN endpoint, byte stream to the USB core
   output logic                     IN_VALID_O,
   output logic [7:0]               IN_DATA_O,
   output logic                     IN_ZLP_O,
   input  wire logic                IN_READY_I,
   output logic                     IN_STALL_O,
   // Stall clear from the interface reset request
   input  wire logic                INTF_RESET_I,
   // Memory engine request and answer
   output logic                     MEM_REQ_O,
   output ubci_mem_req_t            MEM_CMD_O,
   input  wire logic                MEM_DONE_I,
   input  wire logic                MEM_ERR_I,
   input  wire logic                MEM_RD_VALID_I,
   input  wire logic [7:0]          MEM_RD_DATA_I,
   output logic                     MEM_RD_READY_O,
   // Mass-storage control
   output logic                     MSC_WRITE_PROTECT_O,
   output logic                     MSC_MEDIA_ABSENT_O,
   output logic                     MSC_ABORT_DOWNLOAD_O,
   // Restart request
   output logic                     RESTART_O,
   output logic                     RESTART_WATCHDOG_O,
   output logic [31:0]              RESTART_ADDRESS_O,
   output logic [31:0]              RESTART_STACK_O,
   // Status readback
   output ubci_status_t             STATUS_O
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_WAIT, ST_MEM, ST_READ, ST_ACK, ST_STALL
   } ubci_state_t;

   // Little-endian field extraction from the packet
   function automatic logic [31:0] word_at(
      input logic [UBCI_CMD_BYTES*8-1:0] p, input logic [4:0] ofs);
      word_at = p[{ofs, 3'b000} +: 32];
   endfunction
   function automatic logic [7:0] byte_at(
      input logic [UBCI_CMD_BYTES*8-1:0] p, input logic [4:0] ofs);
      byte_at = p[{ofs, 3'b000} +: 8];
   endfunction

   ubci_state_t                  state_ff, nxt_state;
   ubci_cmd_t                    cmd_ff;
   logic [3:0]                   status_ff;
   logic [7:0]                   level_ff;
   logic [31:0]                  ms_left_ff;
   logic [31:0]                  tick_cnt_ff;
   logic [31:0]                  rd_left_ff;
   logic                         mem_req_ff, zlp_ff, restart_ff, abort_ff;
   logic                         in_valid_ff;
   logic [7:0]                   in_data_ff;
   logic                         pkt_valid, pkt_size_ok;
   logic [UBCI_CMD_BYTES*8-1:0]  pkt_data;

   ubci_pkt_asm u_asm (
      .CLK_I         (CLK_I),
      .ARST_N_I      (ARST_N_I),
      .byte_valid_i  (OUT_VALID_I),
      .byte_data_i   (OUT_DATA_I),
      .pkt_end_i     (OUT_PKT_END_I),
      .enable_i      (OUT_READY_O),
      .pkt_valid_o   (pkt_valid),
      .pkt_size_ok_o (pkt_size_ok),
      .pkt_data_o    (pkt_data)
   );

   // Decoded fields of the incoming packet
   // signature and tag
   wire [31:0] pkt_sig   = word_at(pkt_data, UBCI_OFS_SIGNATURE);
   wire [31:0] pkt_tag   = word_at(pkt_data, UBCI_OFS_TAG);
   wire [7:0]  pkt_code  = byte_at(pkt_data, UBCI_OFS_CODE);
   wire [7:0]  pkt_alen  = byte_at(pkt_data, UBCI_OFS_ARGLEN);
   wire [31:0] pkt_pay   = word_at(pkt_data, UBCI_OFS_PAYLOAD);
   wire [31:0] pkt_a0    = word_at(pkt_data, UBCI_OFS_ARGS);
   wire [31:0] pkt_a1    = word_at(pkt_data, UBCI_OFS_ARG1);
   wire [31:0] pkt_a2    = word_at(pkt_data, UBCI_OFS_DELAY);

   // Classification of the latched command
   // direction bit
   wire        dir_in    = |(cmd_ff.command_code & UBCI_DIR_IN_BIT);
   wire        c_access  = cmd_ff.command_code == UBCI_CODE_ACCESS;
   wire        c_restart = cmd_ff.command_code == UBCI_CODE_RESTART;
   wire        c_erase   = cmd_ff.command_code == UBCI_CODE_ERASE;
   wire        c_read    = cmd_ff.command_code == UBCI_CODE_READ;
   wire        known     = c_access | c_restart | c_erase | c_read;
   wire [7:0]  want_len  = c_access  ? UBCI_LEN_ACCESS  :
                           c_restart ? UBCI_LEN_RESTART :
                           c_erase   ? UBCI_LEN_ERASE   : UBCI_LEN_READ;
   // Zero payload only for non-read commands; read needs count match
   // payload equals read count
   wire        pay_ok    = c_read ? (dir_in && cmd_ff.payload_byte_count ==
                                     cmd_ff.arg1)
                                  : (cmd_ff.payload_byte_count == 32'h0);
   // Level above 2 is refused, erase must be sector aligned
   // sector alignment check
   wire        arg_ok    = c_access ? (cmd_ff.arg0[7:0] <= UBCI_LVL_EJECT)
                         : c_erase  ? (((cmd_ff.arg0 | cmd_ff.arg1) &
                                        UBCI_SECTOR_MASK) == 32'h0)
                         : 1'b1;
   wire [3:0]  chk_status = !known                         ? UBCI_ST_UNKNOWN :
                            cmd_ff.argument_length != want_len
                                                           ? UBCI_ST_BAD_LEN :
                            !pay_ok                        ? UBCI_ST_BAD_LEN :
                            !arg_ok                        ? UBCI_ST_BAD_ARG :
                                                             UBCI_ST_OK;
   wire        ms_tick    = (tick_cnt_ff == 32'h0);
   wire        in_take    = in_valid_ff & IN_READY_I;
   wire        rd_take    = MEM_RD_VALID_I & (~in_valid_ff | IN_READY_I);

   // Next state
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (pkt_valid)
               nxt_state = (!pkt_size_ok || pkt_sig != UBCI_SIGNATURE)
                         ? ST_STALL : ST_DECODE;
         ST_DECODE:
            if (chk_status != UBCI_ST_OK)
               nxt_state = ST_STALL;
            else if (c_access)
               nxt_state = ST_ACK;
            else if (c_restart)
               nxt_state = ST_WAIT;
            else
               nxt_state = c_read ? ST_READ : ST_MEM;
         ST_WAIT:
            if (ms_left_ff == 32'h0)
               nxt_state = ST_ACK;
         ST_MEM:
            if (MEM_DONE_I)
               nxt_state = MEM_ERR_I ? ST_STALL : ST_ACK;
         ST_READ:
            if (MEM_ERR_I)
               nxt_state = ST_STALL;
            else if (rd_left_ff == 32'h0 && !in_valid_ff)
               nxt_state = ST_ACK;
         ST_ACK:
            if (IN_READY_I)
               nxt_state = ST_IDLE;
         ST_STALL:
            if (INTF_RESET_I)
               nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // State and latched command
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         state_ff <= ST_IDLE;
         cmd_ff   <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE && pkt_valid)
            cmd_ff <= '{pkt_tag, pkt_code, pkt_alen, pkt_pay,
                        pkt_a0, pkt_a1, pkt_a2};
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         status_ff <= UBCI_ST_OK;
      else if (state_ff == ST_IDLE && pkt_valid)
         status_ff <= (!pkt_size_ok || pkt_sig != UBCI_SIGNATURE)
                    ? UBCI_ST_BAD_SIG : UBCI_ST_OK;
      else if (state_ff == ST_DECODE)
         status_ff <= chk_status;
      else if ((state_ff == ST_MEM && MEM_DONE_I && MEM_ERR_I) ||
               (state_ff == ST_READ && MEM_ERR_I))
         status_ff <= UBCI_ST_MEM_ERR;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         level_ff <= UBCI_LVL_OPEN;
         abort_ff <= 1'b0;
      end
      else
      begin
         abort_ff <= 1'b0;
         if (INTF_RESET_I)
            level_ff <= UBCI_LVL_OPEN;
         else if (state_ff == ST_DECODE && c_access &&
                  chk_status == UBCI_ST_OK)
         begin
            level_ff <= cmd_ff.arg0[7:0];
            abort_ff <= cmd_ff.arg0[7:0] != UBCI_LVL_OPEN;
         end
      end
   end

   // Millisecond divider and delay counter; divider runs only in wait
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         tick_cnt_ff <= 32'h0;
         ms_left_ff  <= 32'h0;
      end
      else if (state_ff == ST_DECODE)
      begin
         tick_cnt_ff <= 32'(MS_CYCLES - 1);
         ms_left_ff  <= cmd_ff.arg2;
      end
      else if (state_ff == ST_WAIT)
      begin
         tick_cnt_ff <= ms_tick ? 32'(MS_CYCLES - 1) : tick_cnt_ff - 32'h1;
         if (ms_tick && ms_left_ff != 32'h0)
            ms_left_ff <= ms_left_ff - 32'h1;
      end
   end

   // Memory job request and read streaming
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         mem_req_ff  <= 1'b0;
         rd_left_ff  <= 32'h0;
         in_valid_ff <= 1'b0;
         in_data_ff  <= 8'h00;
      end
      else
      begin
         mem_req_ff <= state_ff == ST_DECODE && (c_erase || c_read) &&
                       chk_status == UBCI_ST_OK;
         if (state_ff == ST_DECODE)
            rd_left_ff <= cmd_ff.arg1;
         else if (state_ff == ST_READ && rd_take && rd_left_ff != 32'h0)
            rd_left_ff <= rd_left_ff - 32'h1;
         if (state_ff == ST_READ && rd_take && rd_left_ff != 32'h0)
         begin
            in_valid_ff <= 1'b1;
            in_data_ff  <= MEM_RD_DATA_I;
         end
         else if (in_take || state_ff != ST_READ)
            in_valid_ff <= 1'b0;
      end
   end

   // Completion packet and restart request
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         zlp_ff     <= 1'b0;
         restart_ff <= 1'b0;
      end
      else
      begin
         zlp_ff     <= nxt_state == ST_ACK && !(state_ff == ST_ACK &&
                       IN_READY_I);
         restart_ff <= state_ff == ST_ACK && IN_READY_I && c_restart;
      end
   end

   assign OUT_STALL_O          = state_ff == ST_STALL;
   assign IN_STALL_O           = state_ff == ST_STALL;
   assign OUT_READY_O          = state_ff == ST_IDLE && !pkt_valid;
   assign IN_VALID_O           = in_valid_ff;
   assign IN_DATA_O            = in_data_ff;
   assign IN_ZLP_O             = zlp_ff;
   assign MEM_REQ_O            = mem_req_ff;
   assign MEM_CMD_O            = '{c_erase, cmd_ff.arg0, cmd_ff.arg1};
   assign MEM_RD_READY_O       = state_ff == ST_READ &&
                                 (!in_valid_ff || IN_READY_I) &&
                                 rd_left_ff != 32'h0;
   assign MSC_WRITE_PROTECT_O  = level_ff != UBCI_LVL_OPEN;
   assign MSC_MEDIA_ABSENT_O   = level_ff == UBCI_LVL_EJECT;
   assign MSC_ABORT_DOWNLOAD_O = abort_ff;
   assign RESTART_O            = restart_ff;
   assign RESTART_WATCHDOG_O   = cmd_ff.arg0 != 32'h0;
   assign RESTART_ADDRESS_O    = cmd_ff.arg0;
   assign RESTART_STACK_O      = cmd_ff.arg1;
   assign STATUS_O             = '{cmd_ff.request_tag, cmd_ff.command_code,
                                   status_ff, state_ff != ST_IDLE &&
                                   state_ff != ST_STALL};
endmodule

// file: dv/ubci_top_asserts.sv
// Port assertions for the boot command interpreter
`timescale 1ns/10ps
module ubci_top_asserts
#(
   parameter int MS_CYCLES = 10
)
(
   // Clock, reset and bench inputs
   input wire logic       CLK_I,
   input wire logic       ARST_N_I,
   input wire logic       OUT_VALID_I,
   input wire logic       OUT_PKT_END_I,
   input wire logic       IN_READY_I,
   input wire logic       INTF_RESET_I,
   // Design outputs under watch
   input wire logic       OUT_READY_O,
   input wire logic       OUT_STALL_O,
   input wire logic       IN_STALL_O,
   input wire logic       IN_VALID_O,
   input wire logic [7:0] IN_DATA_O,
   input wire logic       IN_ZLP_O,
   input wire logic       MSC_WRITE_PROTECT_O,
   input wire logic       MSC_MEDIA_ABSENT_O,
   input wire logic       MSC_ABORT_DOWNLOAD_O,
   input wire logic       RESTART_O
);
   // One domain, reset mutes every check
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   // Closing byte of a command, and an accepted empty packet
   sequence s_close;
      OUT_VALID_I && OUT_READY_O && OUT_PKT_END_I;
   endsequence
   sequence s_zlp_taken;
      IN_ZLP_O && IN_READY_I;
   endsequence
   // Properties, one per guarded behaviour
   a_one_command: assert property (s_close |=> !OUT_READY_O)
      else $error("ready right after packet close");
   a_stall_sticks: assert property
      (OUT_STALL_O && !INTF_RESET_I |=> OUT_STALL_O && IN_STALL_O)
      else $error("stall lost without interface reset");
   a_zlp_holds: assert property
      (IN_ZLP_O && !IN_READY_I |=> IN_ZLP_O)
      else $error("empty packet dropped before acceptance");
   a_zlp_once: assert property (s_zlp_taken |=> !IN_ZLP_O)
      else $error("empty packet repeated");
   a_byte_holds: assert property
      (IN_VALID_O && !IN_READY_I |=> IN_VALID_O && $stable(IN_DATA_O))
      else $error("read byte changed while waiting");
   a_eject_protect: assert property
      (MSC_MEDIA_ABSENT_O |-> MSC_WRITE_PROTECT_O)
      else $error("drive absent but writable");
   a_abort_pulse: assert property
      (MSC_ABORT_DOWNLOAD_O |=> !MSC_ABORT_DOWNLOAD_O && MSC_WRITE_PROTECT_O)
      else $error("download abort not a single pulse");
   a_restart_after: assert property
      ($rose(RESTART_O) |-> $past(IN_ZLP_O && IN_READY_I)
         || $past(IN_ZLP_O && IN_READY_I, 2))
      else $error("restart without accepted empty packet");
endmodule

// file: dv/ubci_mem_model.sv
// Memory engine model: erase after a set latency, read as a byte stream
`timescale 1ns/10ps
module ubci_mem_model
   import ubci_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          arst_n_i,
   // Job, erase latency and read handshake
   input  wire logic          req_i,
   input  wire ubci_mem_req_t cmd_i,
   input  wire logic [3:0]    lat_i,
   input  wire logic          rd_ready_i,
   // Answers
   output logic               done_o,
   output logic               rd_valid_o,
   output logic [7:0]         rd_data_o
);
   logic        busy_ff;
   logic        erase_ff;
   logic [31:0] addr_ff;
   logic [31:0] left_ff;
   logic [3:0]  wait_ff;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         busy_ff    <= 1'h0;
         done_o     <= 1'h0;
         rd_valid_o <= 1'h0;
         rd_data_o  <= 8'h0;
      end
      else
      begin
         done_o <= 1'h0;
         if (req_i)
         begin
            busy_ff  <= 1'h1;
            erase_ff <= cmd_i.erase;
            addr_ff  <= cmd_i.target_address;
            left_ff  <= cmd_i.request_byte_count;
            wait_ff  <= lat_i;
         end
         else if (busy_ff && erase_ff)
         begin
            // Countdown lets the bench make the erase slow
            wait_ff <= wait_ff - 4'h1;
            busy_ff <= (wait_ff != 4'h0);
            done_o  <= (wait_ff == 4'h0);
         end
         else if (busy_ff && (!rd_valid_o || rd_ready_i))
         begin
            // Released data inverts so a stale byte never passes
            rd_valid_o <= (left_ff != 32'h0);
            rd_data_o  <= (left_ff != 32'h0) ? addr_ff[7:0] : ~rd_data_o;
            addr_ff    <= addr_ff + 32'h1;
            left_ff    <= left_ff - 32'h1;
            busy_ff    <= (left_ff != 32'h0);
         end
      end
   end
endmodule

// file: dv/tb_usb_boot_command_interpreter.sv
// Self-checking bench for the boot command interpreter
`timescale 1ns/10ps
module tb_usb_boot_command_interpreter;
   import ubci_pkg::*;
   localparam int MS = 10;
   // Ports, model wires and bookkeeping
   logic          CLK_I, ARST_N_I, OUT_VALID_I, OUT_PKT_END_I, IN_READY_I;
   logic          INTF_RESET_I, MEM_DONE_I, MEM_RD_VALID_I, OUT_READY_O;
   logic          OUT_STALL_O, IN_VALID_O, IN_ZLP_O, IN_STALL_O, MEM_REQ_O;
   logic          MEM_RD_READY_O, MSC_WRITE_PROTECT_O, MSC_MEDIA_ABSENT_O;
   logic          MSC_ABORT_DOWNLOAD_O, RESTART_O, RESTART_WATCHDOG_O;
   logic [7:0]    OUT_DATA_I, IN_DATA_O, MEM_RD_DATA_I;
   logic [31:0]   RESTART_ADDRESS_O, RESTART_STACK_O;
   logic [3:0]    lat;
   logic [64:0]   rs_seen, req_seen;
   ubci_mem_req_t MEM_CMD_O;
   ubci_status_t  STATUS_O;
   int            num_errors, checks, aborts, restarts;
   // ports found by role, not number; error input tied off
   ubci_top #(.MS_CYCLES(MS)) DUT (.MEM_ERR_I(1'h0), .*);
   ubci_mem_model u_mem (.clk_i(CLK_I), .arst_n_i(ARST_N_I),
      .req_i(MEM_REQ_O), .cmd_i(MEM_CMD_O), .lat_i(lat),
      .rd_ready_i(MEM_RD_READY_O), .done_o(MEM_DONE_I),
      .rd_valid_o(MEM_RD_VALID_I), .rd_data_o(MEM_RD_DATA_I));
   // 100 MHz clock
   initial
   begin
      CLK_I = 1'h0;
      forever #5 CLK_I = ~CLK_I;
   end
   // Pulse monitors sample mid-cycle, clear of the launching edge
   always @(negedge CLK_I)
   begin
      aborts += (MSC_ABORT_DOWNLOAD_O === 1'h1);
      if (RESTART_O === 1'h1)
         rs_seen = {RESTART_WATCHDOG_O, RESTART_ADDRESS_O, RESTART_STACK_O};
      restarts += (RESTART_O === 1'h1);
      if (MEM_REQ_O === 1'h1)
         req_seen = MEM_CMD_O;
   end
   task automatic print_verdict;
      if (num_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [64:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [255:0] pkt(input logic [7:0] code, len,
      input logic [31:0] pay, a0, a1, a2);
      pkt = {32'h0, a2, a1, a0, pay, 16'h0, len, code, 32'h42,
             UBCI_SIGNATURE};
   endfunction
   // Bytes go out first-byte-first, end flag with the last
   task automatic send(input logic [255:0] p, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge CLK_I);
         OUT_VALID_I   <= 1'h1;
         OUT_DATA_I    <= p[8*i +: 8];
         OUT_PKT_END_I <= (i == n - 1);
      end
      @(posedge CLK_I);
      OUT_VALID_I   <= 1'h0;
      OUT_PKT_END_I <= 1'h0;
   endtask
   task automatic zlp(output int c);
      c = 0;
      // Polls a settled level, one cycle per step
      do
      begin
         @(negedge CLK_I);
         c++;
      end
      while (IN_ZLP_O !== 1'h1 && c < 3000);
      chk(IN_ZLP_O, 1'h1);
      @(posedge CLK_I);
      IN_READY_I <= 1'h1;
      @(posedge CLK_I);
      IN_READY_I <= 1'h0;
   endtask
   // Status code 4'hF means the failure code is not compared
   task automatic stall(input logic [3:0] st);
      repeat (4) @(negedge CLK_I);
      chk({OUT_STALL_O, IN_STALL_O}, 2'h3);
      if (st != 4'hF)
         chk(STATUS_O.status, st);
      @(posedge CLK_I);
      INTF_RESET_I <= 1'h1;
      @(posedge CLK_I);
      INTF_RESET_I <= 1'h0;
      @(negedge CLK_I);
      chk({OUT_STALL_O, MSC_WRITE_PROTECT_O, OUT_READY_O}, 3'h1);
   endtask
   task automatic t_access;
      int c;
      for (int lv = 0; lv < 3; lv++)
      begin
         send(pkt(UBCI_CODE_ACCESS, UBCI_LEN_ACCESS, 32'h0, lv, 0, 0), 32);
         zlp(c);
         chk({MSC_WRITE_PROTECT_O, MSC_MEDIA_ABSENT_O},
             {lv > 0, lv > 1});
         chk(aborts, lv);
      end
   endtask
   task automatic t_bad;
      logic [255:0] p;
      p = pkt(UBCI_CODE_ACCESS, UBCI_LEN_ACCESS, 32'h0, 32'h1, 0, 0);
      send(p ^ 256'h1, 32);
      stall(UBCI_ST_BAD_SIG);
      send(p, 31);
      stall(UBCI_ST_BAD_SIG);
      send(pkt(8'h05, 8'h08, 32'h0, 0, 0, 0), 32);
      stall(UBCI_ST_UNKNOWN);
      send(pkt(UBCI_CODE_ACCESS, UBCI_LEN_ACCESS, 32'h0, 32'h3, 0, 0), 32);
      stall(4'hF);
      send(pkt(UBCI_CODE_ACCESS, 8'h02, 32'h0, 32'h1, 0, 0), 32);
      stall(4'hF);
      send(pkt(UBCI_CODE_ACCESS, UBCI_LEN_ACCESS, 32'h4, 32'h1, 0, 0), 32);
      stall(4'hF);
      send(pkt(UBCI_CODE_ERASE, UBCI_LEN_ERASE, 0, 32'h1000_0800,
               32'h1000, 0), 32);
      stall(4'hF);
      send(pkt(UBCI_CODE_READ, UBCI_LEN_READ, 32'h8, 32'h2000_0000,
               32'h4, 0), 32);
      stall(4'hF);
   endtask
   task automatic t_restart;
      int c;
      logic [31:0] a;
      for (int k = 0; k < 2; k++)
      begin
         a = k ? 32'h2000_0100 : 32'h0;
         send(pkt(UBCI_CODE_RESTART, UBCI_LEN_RESTART, 0, a,
                  32'h2004_1000, k + 1), 32);
         zlp(c);
         chk(c >= (k + 1) * MS && c <= (k + 1) * MS + 8, 1'h1);
         repeat (3) @(negedge CLK_I);
         chk(restarts, k + 1);
         chk(rs_seen, {a != 32'h0, a, 32'h2004_1000});
      end
   endtask
   task automatic t_erase;
      int c;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge CLK_I);
         lat <= k ? 4'h9 : 4'h0;
         send(pkt(UBCI_CODE_ERASE, UBCI_LEN_ERASE, 0, 32'h1000_3000,
                  32'h2000, 0), 32);
         zlp(c);
         chk(req_seen, {1'h1, 32'h1000_3000, 32'h2000});
         chk(c > lat, 1'h1);
      end
   endtask
   task automatic t_read;
      int n;
      logic z;
      logic [7:0] e;
      n = 0;
      z = 1'h0;
      e = 8'hFD;
      send(pkt(UBCI_CODE_READ, UBCI_LEN_READ, 32'h5, 32'h2000_00FD,
               32'h5, 0), 32);
      for (int i = 0; i < 200 && !z; i++)
      begin
         @(posedge CLK_I);
         IN_READY_I <= ~IN_READY_I;
         @(negedge CLK_I);
         if (IN_VALID_O === 1'h1 && IN_READY_I === 1'h1)
         begin
            chk(IN_DATA_O, e);
            e++;
            n++;
         end
         z = (IN_ZLP_O === 1'h1 && IN_READY_I === 1'h1);
      end
      @(posedge CLK_I);
      IN_READY_I <= 1'h0;
      chk({z, n}, {1'h1, 32'h5});
      chk(req_seen, {1'h0, 32'h2000_00FD, 32'h5});
   endtask
   // Watchdog at 20000 cycles, far beyond the several hundred cycles needed
   initial
   begin
      #200000
      num_errors++;
      print_verdict();
   end
   // Reset for three cycles, then the scenarios
   initial
   begin
      {ARST_N_I, OUT_VALID_I, OUT_PKT_END_I, IN_READY_I, INTF_RESET_I} = '0;
      OUT_DATA_I = 8'h0;
      lat = 4'h0;
      repeat (3) @(posedge CLK_I);
      ARST_N_I <= 1'h1;
      t_access();
      t_bad();
      t_restart();
      t_erase();
      t_read();
      print_verdict();
   end
endmodule
bind ubci_top ubci_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
